// >>> sink_port_pkg.sv
// Constants, register map and level arithmetic for the sink-current port
package sink_port_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [5:0] IDX_DATA    = 6'h30;
	localparam logic [5:0] IDX_ENABLE  = 6'h31;
	localparam logic [5:0] IDX_EDGE    = 6'h32;
	localparam logic [5:0] IDX_CTRL    = 6'h33;
	localparam logic [5:0] IDX_STATUS  = 6'h34;
	localparam logic [5:0] IDX_MASK    = 6'h35;
	localparam logic [5:0] IDX_PINS    = 6'h36;
	localparam logic [5:0] IDX_SINK0   = 6'h38;
	localparam logic [5:0] IDX_SINK7   = 6'h3f;

	// ==========================================================
	// Field positions and widths
	localparam int         SINK_W      = 4;
	localparam int         LEVEL_W     = 7;
	localparam int         PINS        = 8;
	localparam int         CTRL_SUSPEND_BIT = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] DATA_RST    = 8'hff;
	localparam logic [7:0] ENABLE_RST  = 8'h00;
	localparam logic [7:0] EDGE_RST    = 8'h00;
	localparam logic [7:0] MASK_RST    = 8'h00;
	localparam logic [3:0] SINK_RST    = 4'h0;
	localparam logic       SUSPEND_RST = 1'b0;
	localparam logic       PIN_IDLE    = 1'b1;

	// ==========================================================
	// Sink level in 1/75 of full scale: code 0 is 15/75, code 15 is 75/75
	localparam logic [6:0] LEVEL_MIN   = 7'h0f;
	localparam logic [6:0] LEVEL_STEP  = 7'h04;
	localparam logic [6:0] LEVEL_MAX   = 7'h4b;

	// Level for one code, evenly spaced and monotonic
	function automatic logic [6:0] level_of(input logic [3:0] code);
		level_of = 7'(LEVEL_MIN + 7'(LEVEL_STEP * {3'h0, code}));
	endfunction : level_of

endpackage : sink_port_pkg

// >>> edge_if.sv
// Interface joining the port control to the pin edge detector
interface edge_if;
	logic [7:0] pinIn;
	logic [7:0] polarity;
	logic [7:0] enable;
	logic [7:0] event_;
	logic [7:0] level;

	modport det (input pinIn, input polarity, input enable,
		output event_, output level);
	modport ctl (output pinIn, output polarity, output enable,
		input event_, input level);
endinterface : edge_if

// >>> pin_edge_detect.sv
// Pin synchroniser and per-pin qualified edge detector
module pin_edge_detect
(
	input  wire logic clk,
	input  wire logic sys_rst,
	edge_if.det       bus
);

	logic [7:0] syncA;
	logic [7:0] syncB;
	logic [7:0] prev;
	logic [7:0] rise;
	logic [7:0] fall;

	// ==========================================================
	// Synchroniser
	// Two flops before any logic, so one pin edge gives one event
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			syncA <= {8{sink_port_pkg::PIN_IDLE}};
			syncB <= {8{sink_port_pkg::PIN_IDLE}};
			prev  <= {8{sink_port_pkg::PIN_IDLE}};
		end
		else
		begin
			syncA <= bus.pinIn; // RULE13
			syncB <= syncA;
			prev  <= syncB;
		end
	end

	assign rise = syncB & ~prev;
	assign fall = ~syncB & prev;

	// ==========================================================
	// Qualified events
	// Polarity picks the direction; enable gates the pin
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			bus.event_ <= 8'h00;
		else
			bus.event_ <= bus.enable & ((bus.polarity & rise)
				| (~bus.polarity & fall)); // RULE7 RULE8
	end

	assign bus.level = syncB;

	// ==========================================================
	// Checks
	sequence s_fall;
		!bus.polarity[0] && bus.enable[0] && fall[0];
	endsequence

	sequence s_rise;
		bus.polarity[0] && bus.enable[0] && rise[0];
	endsequence

	AST_FALL_EVENT: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
		s_fall |=> bus.event_[0])
		else $error("falling edge did not raise event");

	AST_RISE_ONCE: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
		s_rise |=> bus.event_[0] ##1 !bus.event_[0])
		else $error("rising edge event not single");

endmodule : pin_edge_detect

// >>> sink_current_port_irq.sv
// Eight-pin programmable current-sink port with edge interrupts on APB
//
// Contract
// [RULE1] Sink code in bits 3..0, 7..4 reserved
// [RULE2] Code zero selects one fifth full scale
// [RULE3] Code all ones full scale, evenly spaced
// [RULE4] Per-pin interrupt enable register at 0x31
// [RULE5] Interrupt enables clear on reset
// [RULE6] All pin events share one interrupt
// [RULE7] Polarity at 0x32: 0 falling, 1 rising
// [RULE8] Event needs enable and selected edge
// [RULE9] Polarity bits clear on reset
// [RULE10] Data one pulls high, zero sinks low
// [RULE11] Sink registers 0x38..0x3F for pins 0..7
// [RULE12] Suspend disables every pin sink
// [RULE13] Synchronise pin inputs before edge detection
//
// The APB slave port was decided locally.
module sink_current_port_irq
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  pinIn,
	output logic      [7:0]  pinOut,
	output logic      [7:0]  pinOe,
	output logic      [7:0]  pullUpEn,
	output logic      [55:0] sinkLevel,
	output logic             irq
);

	logic [7:0] dataReg;
	logic [7:0] enable;
	logic [7:0] edgeSel;
	logic [7:0] status;
	logic [7:0] mask;
	logic       suspend;
	logic [3:0] sinkCode [8];
	logic [5:0] idx;
	logic       setup;
	logic       wrDone;
	logic       mapped;
	logic [31:0] next_prdata;
	logic [7:0] edgeEvent;
	logic [7:0] pinLevel;

	edge_if edges ();

	// ==========================================================
	// Address decode
	function automatic logic is_mapped(input logic [7:0] a);
		logic [5:0] i;
		i = a[7:2];
		is_mapped = (a[1:0] == 2'h0)
			&& (((i >= sink_port_pkg::IDX_DATA)
			&& (i <= sink_port_pkg::IDX_PINS))
			|| ((i >= sink_port_pkg::IDX_SINK0)
			&& (i <= sink_port_pkg::IDX_SINK7)));
	endfunction : is_mapped

	assign idx    = paddr[7:2];
	assign mapped = is_mapped(paddr);
	assign setup  = psel && !penable;
	// Write lands only at the edge that completes the access
	assign wrDone = psel && penable && pready && pwrite && mapped;

	// ==========================================================
	// APB answer: ready in the first cycle of the access phase, no wait states
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			prdata  <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	// Read mux; the write-only map reads back for debug
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		if (idx >= sink_port_pkg::IDX_SINK0)
			next_prdata = {28'h0, sinkCode[3'(idx)]}; // RULE1
		else
		begin
			unique case (idx)
				sink_port_pkg::IDX_DATA:   next_prdata = {24'h0, dataReg};
				sink_port_pkg::IDX_ENABLE: next_prdata = {24'h0, enable};
				sink_port_pkg::IDX_EDGE:   next_prdata = {24'h0, edgeSel};
				sink_port_pkg::IDX_CTRL:   next_prdata = {31'h0, suspend};
				sink_port_pkg::IDX_STATUS: next_prdata = {24'h0, status};
				sink_port_pkg::IDX_MASK:   next_prdata = {24'h0, mask};
				sink_port_pkg::IDX_PINS:   next_prdata = {24'h0, pinLevel};
				default:                   next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dataReg <= sink_port_pkg::DATA_RST;
			enable  <= sink_port_pkg::ENABLE_RST; // RULE5
			edgeSel <= sink_port_pkg::EDGE_RST;   // RULE9
			mask    <= sink_port_pkg::MASK_RST;
			suspend <= sink_port_pkg::SUSPEND_RST;
		end
		else if (wrDone)
		begin
			if (idx == sink_port_pkg::IDX_DATA)
				dataReg <= pwdata[7:0];
			if (idx == sink_port_pkg::IDX_ENABLE)
				enable <= pwdata[7:0]; // RULE4
			if (idx == sink_port_pkg::IDX_EDGE)
				edgeSel <= pwdata[7:0]; // RULE7
			if (idx == sink_port_pkg::IDX_MASK)
				mask <= pwdata[7:0];
			if (idx == sink_port_pkg::IDX_CTRL)
				suspend <= pwdata[sink_port_pkg::CTRL_SUSPEND_BIT];
		end
	end

	// Sink codes, one register per pin in address order
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < sink_port_pkg::PINS; i++)
				sinkCode[i] <= sink_port_pkg::SINK_RST;
		end
		else if (wrDone && idx >= sink_port_pkg::IDX_SINK0)
			sinkCode[3'(idx)] <= pwdata[3:0]; // RULE11 RULE1
	end

	// ==========================================================
	// Edge detection
	assign edges.pinIn    = pinIn;
	assign edges.polarity = edgeSel;
	assign edges.enable   = enable;
	assign edgeEvent      = edges.event_;
	assign pinLevel       = edges.level;

	pin_edge_detect u_edge
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.bus     (edges)
	);

	// ==========================================================
	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			status <= 8'h00;
		else if (wrDone && idx == sink_port_pkg::IDX_STATUS)
			status <= (status & ~pwdata[7:0]) | edgeEvent;
		else
			status <= status | edgeEvent;
	end

	// One shared level request for all pins
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(status & mask); // RULE6
	end

	// ==========================================================
	// Pin drive: open-drain sink, pull-up when data is one
	// A pin at zero while suspended floats; software should load ones
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pinOut   <= 8'h00;
			pinOe    <= 8'h00;
			pullUpEn <= sink_port_pkg::DATA_RST;
		end
		else
		begin
			pinOut   <= 8'h00;
			pinOe    <= ~dataReg & {8{!suspend}}; // RULE10 RULE12
			pullUpEn <= dataReg;                  // RULE10
		end
	end

	// Level code per pin, seven bits each
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sinkLevel <= {8{sink_port_pkg::LEVEL_MIN}};
		else
		begin
			for (int i = 0; i < sink_port_pkg::PINS; i++)
				sinkLevel[i*7 +: 7] <= sink_port_pkg::level_of(sinkCode[i]); // RULE2 RULE3
		end
	end

	// ==========================================================
	// Checks
	sequence s_sink_read;
		setup && !pwrite && mapped && idx >= sink_port_pkg::IDX_SINK0;
	endsequence

	sequence s_status_write;
		wrDone && idx == sink_port_pkg::IDX_STATUS;
	endsequence

	AST_RESV_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
		s_sink_read |=> pready && prdata[31:4] == 28'h0)
		else $error("sink read shows reserved bits");

	AST_MIN_LEVEL: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
		sinkCode[0] == 4'h0 |=> sinkLevel[6:0] == sink_port_pkg::LEVEL_MIN)
		else $error("code zero is not one fifth");

	AST_MAX_LEVEL: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
		sinkCode[7] == 4'hf |=> sinkLevel[55:49] == sink_port_pkg::LEVEL_MAX)
		else $error("code fifteen is not full scale");

	AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
		wrDone && idx == sink_port_pkg::IDX_ENABLE
		|=> enable == $past(pwdata[7:0]))
		else $error("enable register not written");

	AST_ENABLE_RESET: assert property (@(posedge clk) // RULE5
		sys_rst |=> enable == 8'h00)
		else $error("enables not cleared by reset");

	AST_EDGE_RESET: assert property (@(posedge clk) // RULE9
		sys_rst |=> edgeSel == 8'h00)
		else $error("polarity not cleared by reset");

	AST_EVENT_STICKY: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
		edgeEvent[0] |=> status[0] ##1 (irq || !$past(mask[0])))
		else $error("event lost or not reported");

	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
		(status & mask) == 8'h00 |=> !irq)
		else $error("interrupt without masked status");

	AST_NO_EVENT_DISABLED: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
		(enable == 8'h00) [*2] |-> edgeEvent == 8'h00)
		else $error("event from a disabled pin");

	AST_SUSPEND_OFF: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
		suspend |=> pinOe == 8'h00)
		else $error("sink active in suspend");

	AST_DATA_DRIVE: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
		!suspend |=> pullUpEn == $past(dataReg) && pinOe == ~$past(dataReg))
		else $error("pin drive does not follow data");

	AST_CLEAR_WINDOW: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
		s_status_write ##0 edgeEvent[1] |=> status[1])
		else $error("event lost under clear");

	// Register writes land at the completing edge, seen one edge on
	sequence s_sink0_write;
		wrDone && idx == sink_port_pkg::IDX_SINK0;
	endsequence

	sequence s_edge_write;
		wrDone && idx == sink_port_pkg::IDX_EDGE;
	endsequence

	AST_SINK_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
		s_sink0_write |=> sinkCode[0] == $past(pwdata[3:0]))
		else $error("pin zero sink code not written");

	AST_EDGE_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
		s_edge_write |=> edgeSel == $past(pwdata[7:0]))
		else $error("polarity register not written");

	AST_IRQ_RAISE: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
		(status & mask) != 8'h00 |=> irq)
		else $error("pending unmasked status without interrupt");

	// A one with no event on that pin drops the bit
	AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
		s_status_write ##0 (pwdata[2] && !edgeEvent[2]) |=> !status[2])
		else $error("status bit not cleared by a one");

	// Suspend leaves the pull-ups to the data register
	AST_SUSPEND_PULL: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
		suspend |=> pullUpEn == $past(dataReg))
		else $error("pull-up does not follow data in suspend");

endmodule : sink_current_port_irq

// >>> pin_load_model.sv
// Behavioural model of the external loads on the eight sink pins
module pin_load_model
(
	input  wire logic       clk,
	input  wire logic [7:0] pinOe,
	input  wire logic [7:0] pullUpEn,
	input  wire logic [7:0] extDrive,
	input  wire logic [7:0] extVal,
	output logic      [7:0] pinLvl
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] lastLvl = 8'hff;

	// ==========================================================
	// Pin level: the sink wins, then a load, then the pull-up
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (pinOe[i])
				pinLvl[i] = 1'b0;
			else if (extDrive[i])
				pinLvl[i] = extVal[i];
			else if (pullUpEn[i])
				pinLvl[i] = 1'b1;
			else
				pinLvl[i] = ~lastLvl[i]; // Floating, never a stale value
		end
	end

	// Last level, so a floating pin keeps wandering
	always @(posedge clk)
		lastLvl <= pinLvl;
endmodule : pin_load_model

// >>> test_sink_current_port_irq.sv
// Self-checking bench for the sink-current port with edge interrupts
`define CHK(nm, e, g) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("wrong value %s exp %0h got %0h", nm, e, g); \
		end \
	end

module test_sink_current_port_irq;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk      = 1'b0;
	logic        sys_rst  = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic [7:0]  extDrive = 8'hff;
	logic [7:0]  extVal   = 8'hff;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  pinIn;
	logic [7:0]  pinOut;
	logic [7:0]  pinOe;
	logic [7:0]  pullUpEn;
	logic [55:0] sinkLevel;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          bad_count  = 0;
	int          num_checks = 0;
	int          seed       = 32'h00b3;

	// ==========================================================
	// Clock, design and load model
	always #5 clk = ~clk;

	sink_current_port_irq dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
		.sinkLevel(sinkLevel), .irq(irq));

	pin_load_model load_u (.clk(clk), .pinOe(pinOe), .pullUpEn(pullUpEn),
		.extDrive(extDrive), .extVal(extVal), .pinLvl(pinIn));

	// ==========================================================
	// Helpers
	function automatic logic [6:0] lvl(input logic [3:0] c);
		lvl = 7'(7'h0f + 7'(7'h04 * {3'h0, c}));
	endfunction : lvl

	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	// One APB transfer; ready, data and error taken at one rising edge
	task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			bad_count++;
			give_verdict();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [7:0] v;
		logic [3:0] c;
		logic       p;
		int         j;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		`CHK("irq", 1'b0, irq)
		`CHK("pullUpEn", 8'hff, pullUpEn)
		`CHK("pinOe", 8'h00, pinOe)
		`CHK("pinOut", 8'h00, pinOut)
		`CHK("sinkLevel", {8{7'h0f}}, sinkLevel)
		apb(1'b0, sink_port_pkg::IDX_ENABLE, 32'h0);
		`CHK("enable", 32'h0, rd)
		apb(1'b0, sink_port_pkg::IDX_EDGE, 32'h0);
		`CHK("edge", 32'h0, rd)
		// Sink codes, both end codes included, junk in reserved bits
		for (int i = 0; i < 8; i++)
		begin
			c = (i == 0) ? 4'h0 : (i == 7) ? 4'hf : 4'($random(seed));
			apb(1'b1, 6'(sink_port_pkg::IDX_SINK0 + i),
				{28'($random(seed)), c});
			settle(1);
			`CHK("level", lvl(c), sinkLevel[7*i +: 7])
			apb(1'b0, 6'(sink_port_pkg::IDX_SINK0 + i), 32'h0);
			`CHK("sink", {28'h0, c}, rd)
		end
		// Data bits, then suspend over them
		repeat (4)
		begin
			v = 8'($random(seed));
			apb(1'b1, sink_port_pkg::IDX_DATA, {24'h0, v});
			settle(1);
			`CHK("pinOe", ~v, pinOe)
			`CHK("pullUpEn", v, pullUpEn)
			apb(1'b1, sink_port_pkg::IDX_CTRL, 32'h1);
			settle(1);
			`CHK("pinOe", 8'h00, pinOe)
			apb(1'b1, sink_port_pkg::IDX_CTRL, 32'h0);
			settle(1);
			`CHK("pinOe", ~v, pinOe)
		end
		apb(1'b1, sink_port_pkg::IDX_DATA, 32'hff);
		apb(1'b0, 6'h37, 32'h0);
		`CHK("pslverr", 1'b1, err)
		`CHK("rd", 32'h0, rd)
		// Each pin, each polarity; a neighbour edges but is disabled
		apb(1'b1, sink_port_pkg::IDX_MASK, 32'hff);
		for (int q = 0; q < 2; q++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				p = q[0];
				j = (i + 1) % 8;
				@(posedge clk);
				extVal <= {8{~p}};
				settle(6);
				apb(1'b1, sink_port_pkg::IDX_STATUS, 32'hff);
				apb(1'b1, sink_port_pkg::IDX_EDGE, {24'h0, {8{p}}});
				apb(1'b1, sink_port_pkg::IDX_ENABLE, 32'h1 << i);
				extVal[i] <= p;
				extVal[j] <= p;
				settle(8);
				`CHK("irq", 1'b1, irq)
				apb(1'b0, sink_port_pkg::IDX_STATUS, 32'h0);
				`CHK("status", 32'h1 << i, rd)
				apb(1'b1, sink_port_pkg::IDX_STATUS, 32'h1 << i);
				settle(2);
				`CHK("irq", 1'b0, irq)
				@(posedge clk);
				extVal[i] <= ~p;
				settle(8);
				`CHK("irq", 1'b0, irq)
			end
		end
		// Masked event stays pending, then shows when unmasked
		apb(1'b1, sink_port_pkg::IDX_EDGE, 32'h0);
		apb(1'b1, sink_port_pkg::IDX_ENABLE, 32'hff);
		apb(1'b1, sink_port_pkg::IDX_MASK, 32'h0);
		apb(1'b1, sink_port_pkg::IDX_STATUS, 32'hff);
		extVal[0] <= 1'b0;
		settle(8);
		`CHK("irq", 1'b0, irq)
		apb(1'b0, sink_port_pkg::IDX_STATUS, 32'h0);
		`CHK("status", 32'h1, rd)
		apb(1'b1, sink_port_pkg::IDX_MASK, 32'hff);
		settle(2);
		`CHK("irq", 1'b1, irq)
		apb(1'b1, sink_port_pkg::IDX_STATUS, 32'h1);
		settle(2);
		`CHK("irq", 1'b0, irq)
		// Pin 1 falls so its event meets a clear of all bits
		@(posedge clk);
		extVal[1] <= 1'b1;
		settle(6);
		@(posedge clk);
		extVal[1] <= 1'b0;
		@(posedge clk);
		apb(1'b1, sink_port_pkg::IDX_STATUS, 32'hff);
		apb(1'b0, sink_port_pkg::IDX_STATUS, 32'h0);
		`CHK("status", 32'h2, rd)
		// Reset in mid-run puts enables, polarity and data back
		apb(1'b1, sink_port_pkg::IDX_EDGE, 32'hff);
		apb(1'b1, sink_port_pkg::IDX_DATA, 32'h0);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		`CHK("pullUpEn", 8'hff, pullUpEn)
		apb(1'b0, sink_port_pkg::IDX_ENABLE, 32'h0);
		`CHK("enable", 32'h0, rd)
		apb(1'b0, sink_port_pkg::IDX_EDGE, 32'h0);
		`CHK("edge", 32'h0, rd)
		give_verdict();
	end
endmodule : test_sink_current_port_irq
